// [inc/fan_ramp_map.svh]
// Register offsets, field positions, reset values and timing counts of the fan ramp block
// Overview of operation
// [RULE1] Below low threshold, drive B: 0% or minimum
// [RULE2] Below low threshold, drive C: 0% or minimum
// [RULE3] Floor control register resets to all zeros
// [RULE4] Lock bit makes acoustic registers ignore writes
// [RULE5] Per-channel slowdown bit makes ramping four times slower
// [RULE6] Three-bit code sets local channel ramp rate
// [RULE7] Local-channel changes step gradually, never jump
// [RULE8] Codes give increments 1,2,3,4,8,12,24,48 per slot
// [RULE9] Slow timebase stretches full ramp to 52.2 s
// [RULE10] Each update moves duty at most one increment
`ifndef FAN_RAMP_MAP_SVH
`define FAN_RAMP_MAP_SVH

// Register indices; byte address is four times the index
`define FLOOR_CTRL_INDEX   8'h62
`define CONFIG6_INDEX      8'h10
`define LOCAL_RAMP_INDEX   8'h63
`define GLOBAL_CFG_INDEX   8'h40
`define DUTY_STATUS_INDEX  8'h70

// Reset values
`define FLOOR_CTRL_RESET   8'h00
`define CONFIG6_RESET      8'h00
`define LOCAL_RAMP_RESET   8'h00
`define GLOBAL_CFG_RESET   8'h00

// Field positions
`define CHAN_B_FLOOR_BIT   6
`define CHAN_C_FLOOR_BIT   7
`define SLOW_TIMEBASE_BIT  7
`define CHAN_B_SLOW_BIT    1
`define CHAN_C_SLOW_BIT    2
`define LOCK_BIT           1
`define SLOWDOWN_LAST      2'h3

// Duty increments per slot for codes 000 to 111
`define RATE_INC_0         8'h01
`define RATE_INC_1         8'h02
`define RATE_INC_2         8'h03
`define RATE_INC_3         8'h04
`define RATE_INC_4         8'h08
`define RATE_INC_5         8'h0C
`define RATE_INC_6         8'h18
`define RATE_INC_7         8'h30

// Timing: full 0 to 100 percent ramp at one step per slot
`define CLK_PERIOD_NS      4
`define FULL_RAMP_MS       37500
`define FULL_RAMP_SLOW_MS  52200
`define DUTY_FULL_SCALE    255
`define SLOT_CYCLES_CALC ((64'd`FULL_RAMP_MS * 64'd1000000) / \
  (64'd`CLK_PERIOD_NS * 64'd`DUTY_FULL_SCALE))
`define SLOT_SLOW_CYCLES_CALC ((64'd`FULL_RAMP_SLOW_MS * 64'd1000000) / \
  (64'd`CLK_PERIOD_NS * 64'd`DUTY_FULL_SCALE))

`endif

// [inc/fan_ramp_pkg.sv]
// Types shared by the fan ramp block
package fan_ramp_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE  = 1'b0,
    BUS_WRITE = 1'b1
  } bus_state_type;
  typedef logic [7:0] duty_type;
  typedef logic [2:0] rate_code_type;
endpackage

// [rtl/fan_ramp_and_floor_control.sv]
// Fan drive floor selection and local-channel ramp limiting with an AHB-Lite register slave
`timescale 1ns/1ps
`include "fan_ramp_map.svh"

module fan_ramp_and_floor_control
  import fan_ramp_pkg::*;
#(
  parameter logic [31:0] SLOT_CYCLES      = 32'(`SLOT_CYCLES_CALC),
  parameter logic [31:0] SLOT_SLOW_CYCLES = 32'(`SLOT_SLOW_CYCLES_CALC)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        auto_mode,
  input  wire logic        below_low_b,
  input  wire logic        below_low_c,
  input  wire logic [7:0]  target_duty_b,
  input  wire logic [7:0]  target_duty_c,
  input  wire logic [7:0]  min_duty_b,
  input  wire logic [7:0]  min_duty_c,
  input  wire logic        local_src_b,
  input  wire logic        local_src_c,
  output logic      [7:0]  fan_drive_b,
  output logic      [7:0]  fan_drive_c
);

  // Increment per slot for a ramp code
  function automatic duty_type rate_increment(input rate_code_type code);
    duty_type inc;
    case (code)
      3'h0: inc = `RATE_INC_0; // RULE8
      3'h1: inc = `RATE_INC_1;
      3'h2: inc = `RATE_INC_2;
      3'h3: inc = `RATE_INC_3;
      3'h4: inc = `RATE_INC_4;
      3'h5: inc = `RATE_INC_5;
      3'h6: inc = `RATE_INC_6;
      default: inc = `RATE_INC_7;
    endcase
    return inc;
  endfunction

  // Word address match against a register index
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] index);
    return (addr == {22'h000000, index, 2'b00});
  endfunction

  // Register and bus state
  bus_state_type bus_state;
  bus_state_type next_bus_state;
  logic [31:0]   write_addr;
  logic [31:0]   next_write_addr;
  logic [31:0]   next_hrdata;
  logic [7:0]    floor_ctrl;
  logic [7:0]    next_floor_ctrl;
  logic [7:0]    config6;
  logic [7:0]    next_config6;
  logic [7:0]    local_ramp;
  logic [7:0]    next_local_ramp;
  logic [7:0]    global_cfg;
  logic [7:0]    next_global_cfg;
  logic          lock;
  logic          addr_phase;

  // Slot timebase
  logic [31:0]   slot_count;
  logic [31:0]   next_slot_count;
  logic [31:0]   slot_limit;
  logic          slot_tick;

  // Per-channel views
  logic [7:0]    chan_target [2];
  logic [7:0]    chan_min [2];
  logic          chan_below [2];
  logic          chan_local [2];
  logic          chan_floor_sel [2];
  logic          chan_slow [2];
  logic [7:0]    chan_duty [2];
  duty_type      step_inc;

  assign lock = global_cfg[`LOCK_BIT];
  assign addr_phase = hsel && htrans[1] && hready;
  assign step_inc = rate_increment(local_ramp[2:0]); // RULE6

  // Channel B and C inputs and control bits
  assign chan_target[0] = target_duty_b;
  assign chan_target[1] = target_duty_c;
  assign chan_min[0] = min_duty_b;
  assign chan_min[1] = min_duty_c;
  assign chan_below[0] = below_low_b;
  assign chan_below[1] = below_low_c;
  assign chan_local[0] = local_src_b;
  assign chan_local[1] = local_src_c;
  assign chan_floor_sel[0] = floor_ctrl[`CHAN_B_FLOOR_BIT];
  assign chan_floor_sel[1] = floor_ctrl[`CHAN_C_FLOOR_BIT];
  assign chan_slow[0] = config6[`CHAN_B_SLOW_BIT];
  assign chan_slow[1] = config6[`CHAN_C_SLOW_BIT];

  // Bus next state: capture writes, return read data
  always_comb begin
    next_bus_state  = bus_state;
    next_write_addr = write_addr;
    next_hrdata     = hrdata;
    next_floor_ctrl = floor_ctrl;
    next_config6    = config6;
    next_local_ramp = local_ramp;
    next_global_cfg = global_cfg;
    case (bus_state)
      BUS_WRITE: begin
        if (lock) begin
          next_bus_state = BUS_IDLE; // RULE4
        end else if (reg_hit(write_addr, `FLOOR_CTRL_INDEX)) begin
          next_floor_ctrl = hwdata[7:0];
        end else if (reg_hit(write_addr, `CONFIG6_INDEX)) begin
          next_config6 = hwdata[7:0];
        end else if (reg_hit(write_addr, `LOCAL_RAMP_INDEX)) begin
          next_local_ramp = hwdata[7:0];
        end else if (reg_hit(write_addr, `GLOBAL_CFG_INDEX)) begin
          next_global_cfg = hwdata[7:0];
        end
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
    if (addr_phase) begin
      next_hrdata = 32'h00000000;
      if (hwrite) begin
        next_bus_state  = BUS_WRITE;
        next_write_addr = haddr;
      end else if (reg_hit(haddr, `FLOOR_CTRL_INDEX)) begin
        next_hrdata = {24'h000000, floor_ctrl};
      end else if (reg_hit(haddr, `CONFIG6_INDEX)) begin
        next_hrdata = {24'h000000, config6};
      end else if (reg_hit(haddr, `LOCAL_RAMP_INDEX)) begin
        next_hrdata = {24'h000000, local_ramp};
      end else if (reg_hit(haddr, `GLOBAL_CFG_INDEX)) begin
        next_hrdata = {24'h000000, global_cfg};
      end else if (reg_hit(haddr, `DUTY_STATUS_INDEX)) begin
        next_hrdata = {16'h0000, chan_duty[1], chan_duty[0]};
      end
    end
  end

  // Bus and register flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state  <= BUS_IDLE;
      write_addr <= 32'h00000000;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      floor_ctrl <= `FLOOR_CTRL_RESET; // RULE3
      config6    <= `CONFIG6_RESET;
      local_ramp <= `LOCAL_RAMP_RESET;
      global_cfg <= `GLOBAL_CFG_RESET;
    end else if (clk_en) begin
      bus_state  <= next_bus_state;
      write_addr <= next_write_addr;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      floor_ctrl <= next_floor_ctrl;
      config6    <= next_config6;
      local_ramp <= next_local_ramp;
      global_cfg <= next_global_cfg;
    end
  end

  // Slot timebase, normal or stretched
  always_comb begin
    slot_limit = config6[`SLOW_TIMEBASE_BIT] ? SLOT_SLOW_CYCLES : SLOT_CYCLES; // RULE9
    slot_tick  = (slot_count >= slot_limit - 32'h00000001);
    next_slot_count = slot_tick ? 32'h00000000 : slot_count + 32'h00000001;
  end

  // Slot counter register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_count <= 32'h00000000;
    end else if (clk_en) begin
      slot_count <= next_slot_count;
    end
  end

  // Per-channel floor selection and ramp stepping
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [1:0] slow_count;
      logic [1:0] next_slow_count;
      logic [7:0] goal;
      logic [7:0] diff;
      logic [7:0] next_duty;
      logic       step_now;

      // Goal, step enable and next duty
      always_comb begin
        goal = chan_target[ch];
        if (auto_mode && chan_below[ch]) begin
          goal = chan_floor_sel[ch] ? chan_min[ch] : 8'h00; // RULE1 RULE2
        end
        next_slow_count = slow_count;
        step_now = 1'b0;
        if (slot_tick) begin
          next_slow_count = slow_count + 2'h1;
          step_now = !chan_slow[ch] || (slow_count == `SLOWDOWN_LAST); // RULE5
        end
        next_duty = chan_duty[ch];
        diff = 8'h00;
        if (!chan_local[ch]) begin
          next_duty = goal;
        end else if (step_now && (chan_duty[ch] < goal)) begin
          diff = goal - chan_duty[ch];
          next_duty = chan_duty[ch] + ((diff < step_inc) ? diff : step_inc); // RULE7 RULE10
        end else if (step_now && (chan_duty[ch] > goal)) begin
          diff = chan_duty[ch] - goal;
          next_duty = chan_duty[ch] - ((diff < step_inc) ? diff : step_inc); // RULE7 RULE10
        end
      end

      // Channel duty and slowdown counter registers
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          slow_count    <= 2'h0;
          chan_duty[ch] <= 8'h00;
        end else if (clk_en) begin
          slow_count    <= next_slow_count;
          chan_duty[ch] <= next_duty;
        end
      end
    end
  endgenerate

  // Drive outputs straight from the duty flip-flops
  assign fan_drive_b = chan_duty[0];
  assign fan_drive_c = chan_duty[1];

endmodule

// [sim/fan_ramp_monitor.sv]
// Port checker for the fan ramp and floor block
`timescale 1ns/1ps
module fan_ramp_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        clk_en,
  input wire logic        auto_mode,
  input wire logic        below_low_b,
  input wire logic [7:0]  target_duty_b,
  input wire logic [7:0]  target_duty_c,
  input wire logic [7:0]  min_duty_b,
  input wire logic        local_src_b,
  input wire logic        local_src_c,
  input wire logic [7:0]  fan_drive_b,
  input wire logic [7:0]  fan_drive_c
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Zero wait OKAY slave, data in the low 16 bits
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not okay");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000) else $error("hrdata upper set");
  // Unlimited changes land on the next edge
  jump_b_a: assert property (clk_en && !local_src_b && !auto_mode |=>
    fan_drive_b == $past(target_duty_b)) else $error("drive b missed target");
  jump_c_a: assert property (clk_en && !local_src_c && !auto_mode |=>
    fan_drive_c == $past(target_duty_c)) else $error("drive c missed target");
  floor_zero_a: assert property (clk_en && auto_mode && below_low_b && !local_src_b &&
    min_duty_b == 8'h00 |=> fan_drive_b == 8'h00) else $error("drive b floor not zero");
  // Limited changes never exceed the largest step nor pass the goal
  step_limit_a: assert property (clk_en && local_src_b |=>
    fan_drive_b - $past(fan_drive_b) <= 8'h30 || $past(fan_drive_b) - fan_drive_b <= 8'h30)
    else $error("drive b step too large");
  no_overshoot_a: assert property (clk_en && local_src_b && !auto_mode &&
    fan_drive_b < target_duty_b |=> fan_drive_b >= $past(fan_drive_b) &&
    fan_drive_b <= $past(target_duty_b)) else $error("drive b overshoot");
endmodule
bind fan_ramp_and_floor_control fan_ramp_monitor mon_i (.hclk, .hresetn, .hrdata, .hreadyout,
  .hresp, .clk_en, .auto_mode, .below_low_b, .target_duty_b, .target_duty_c, .min_duty_b,
  .local_src_b, .local_src_c, .fan_drive_b, .fan_drive_c);

// [sim/tb.sv]
// Self-checking bench for the fan ramp and floor block
`timescale 1ns/1ps
module tb;
  import fan_ramp_pkg::*;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        auto_mode, below_low_b, below_low_c, local_src_b, local_src_c;
  duty_type    target_duty_b, target_duty_c, min_duty_b, min_duty_c, fan_drive_b, fan_drive_c;
  logic [7:0]  m [512];
  int          mismatches, n_compared, cycles;
  int          incs[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  int          rcfg[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 128, 2, 6};
  int          rcode[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 3, 4, 4};
  int          rgap[11] = '{8, 8, 8, 8, 8, 8, 8, 8, 11, 32, 32};
  assign hready = hreadyout;
  fan_ramp_and_floor_control #(.SLOT_CYCLES(32'd8), .SLOT_SLOW_CYCLES(32'd11))
    fan_ramp_and_floor_control_i (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .auto_mode, .below_low_b,
    .below_low_c, .target_duty_b, .target_duty_c, .min_duty_b, .min_duty_c, .local_src_b,
    .local_src_c, .fan_drive_b, .fan_drive_c);
  // Clock and hang limit
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single transfer; model registers follow unlocked writes
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    if (w && !m[9'h100][1] && a inside {32'h188, 32'h40, 32'h18C, 32'h100}) m[a[8:0]] = d[7:0];
  endtask
  task automatic rd(logic [31:0] a);
    bus(1'b0, a, 32'h0);
    chk(r, {24'h0, m[a[8:0]]});
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    foreach (m[i]) m[i] = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // Ramp from 0 to full scale, checking each step size and spacing
  task automatic ramp(int cfg, int code, int gap);
    int prev;
    int last;
    int n;
    bus(1'b1, 32'h40, cfg);
    bus(1'b1, 32'h18C, code);
    local_src_b <= 1'b0;
    local_src_c <= 1'b0;
    target_duty_b <= 8'h00;
    target_duty_c <= 8'h00;
    repeat (3) @(posedge hclk);
    target_duty_b <= 8'hFF;
    target_duty_c <= 8'hFF;
    local_src_b <= 1'b1;
    local_src_c <= 1'b1;
    prev = 0;
    last = -1;
    n = 0;
    while (prev != 255 && n < 5000) begin
      @(posedge hclk);
      #1 n++;
      if (fan_drive_b !== 8'(prev)) begin
        prev = (prev + incs[code] > 255) ? 255 : prev + incs[code];
        chk(fan_drive_b, prev);
        if (last >= 0) chk(n - last, gap);
        last = n;
      end
      if (cfg[1] == cfg[2]) chk(fan_drive_c, prev);
    end
    chk(prev, 255);
    chk(fan_drive_c, 32'h000000FF);
  endtask
  // Main sequence
  initial begin
    void'($urandom(6739));
    {hsel, hwrite, haddr, hwdata, htrans, auto_mode, below_low_b, below_low_c} = 0;
    {local_src_b, local_src_c, target_duty_b, target_duty_c, min_duty_b, min_duty_c} = 0;
    hsize = 3'h2;
    clk_en = 1'b1;
    do_reset();
    foreach (rgap[i]) rd(32'h4 * (i < 5 ? 98 + i : 255));
    for (int i = 0; i < 6; i++) begin
      target_duty_b <= 8'($urandom);
      target_duty_c <= 8'($urandom);
      repeat (2) @(posedge hclk);
      #1 chk(fan_drive_b, target_duty_b);
      chk(fan_drive_c, target_duty_c);
      bus(1'b0, 32'h1C0, 32'h0);
      chk(r, {16'h0, target_duty_c, target_duty_b});
    end
    // Clock enable low freezes the drive
    clk_en <= 1'b0;
    target_duty_b <= 8'(~target_duty_b);
    repeat (4) @(posedge hclk);
    #1 chk(fan_drive_b, 8'(~target_duty_b));
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk(fan_drive_b, target_duty_b);
    @(posedge hclk);
    auto_mode <= 1'b1;
    below_low_b <= 1'b1;
    below_low_c <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 32'h188, {24'h0, i[1:0], 6'h00});
      min_duty_b <= i[2] ? 8'($urandom) : 8'h00;
      min_duty_c <= 8'($urandom);
      repeat (2) @(posedge hclk);
      #1 chk(fan_drive_b, i[0] ? min_duty_b : 8'h00);
      chk(fan_drive_c, i[1] ? min_duty_c : 8'h00);
      rd(32'h188);
    end
    auto_mode <= 1'b0;
    foreach (rcfg[k]) ramp(rcfg[k], rcode[k], rgap[k]);
    bus(1'b1, 32'h100, 32'h02);
    bus(1'b1, 32'h188, 32'h40);
    bus(1'b1, 32'h100, 32'h00);
    rd(32'h188);
    rd(32'h100);
    do_reset();
    rd(32'h188);
    bus(1'b1, 32'h188, 32'h80);
    rd(32'h188);
    stop_test();
  end
endmodule
